// *** hw/fwal_defs.vh ***
// Constants for the fault, warning and alert logic.
`ifndef FWAL_DEFS_VH
`define FWAL_DEFS_VH
// Command codes of the registers this block answers.
`define FWAL_CMD_MFR_STATUS 8'h80
`define FWAL_CMD_ALERT1_CFG 8'hd5
`define FWAL_CMD_ALERT2_CFG 8'hd6
`define FWAL_CMD_ALERT_CTRL 8'hd8
`define FWAL_CMD_STATUS_ALL 8'he0
// Reset values of the alert enable sets and control.
`define FWAL_ALERT1_RST 16'h8000
`define FWAL_ALERT2_RST 16'h0000
`define FWAL_CTRL_RST 8'h00
// Fields of the alert control register.
`define FWAL_CTRL_INV1 0
`define FWAL_CTRL_INV2 1
`define FWAL_CTRL_W2_UNDER 2
`define FWAL_CTRL_RANGE50 3
// Status bit positions.
`define FWAL_ST_UV 0
`define FWAL_ST_OV 1
`define FWAL_ST_OC 2
`define FWAL_ST_COMM_ERR 3
`define FWAL_ST_REG_ACTIVE 4
`define FWAL_ST_IOC 5
`define FWAL_ST_IW2 6
`define FWAL_ST_VINUV 7
`define FWAL_ST_VINOV 8
`define FWAL_ST_VAUXUV 9
`define FWAL_ST_VAUXOV 10
`define FWAL_ST_PINOP 11
`define FWAL_ST_FET 15
// Shutdown cause codes.
`define FWAL_CAUSE_NONE 2'h0
`define FWAL_CAUSE_UV 2'h1
`define FWAL_CAUSE_OV 2'h2
`define FWAL_CAUSE_OC 2'h3
// Code conversion: offset of zero sense voltage, sense step sizes in nV, voltage steps in uV.
`define FWAL_SENSE_ZERO 12'h800
`define FWAL_LSB25_NV 16'd12400
`define FWAL_LSB50_NV 16'd24770
`define FWAL_LSBV_UV 9'd368
`define FWAL_HALF_LSBV_UV 9'd184
`endif

// *** hw/fwal_alert_logic.v ***
// Fault and warning latching, alert pin drive and alert response for a hot swap controller.
`timescale 1ns/1ps
`include "fwal_defs.vh"
module fwal_alert_logic #(
  parameter ADC_W = 12
) (
  input wire ref_clk,
  input wire rst_n,
  input wire clk_en,
  input wire upper_undervolt_pin,
  input wire lower_undervolt_pin,
  input wire high_threshold_sense_pin,
  input wire overcurrent_timeout,
  input wire current_regulation_active_flag,
  input wire fet_health_bad,
  input wire comm_error_flag,
  input wire hot_swap_on_off_command,
  input wire clear_faults,
  input wire cmd_wr,
  input wire cmd_rd,
  input wire [7:0] cmd_code,
  input wire [15:0] cmd_wr_data,
  output reg [15:0] cmd_rd_data,
  input wire current_sample_valid,
  input wire [ADC_W-1:0] current_reading,
  input wire voltage_sample_valid,
  input wire [ADC_W-1:0] input_voltage_reading,
  input wire [ADC_W-1:0] aux_voltage_reading,
  input wire power_sample_valid,
  input wire [15:0] power_reading,
  input wire [ADC_W-1:0] overcurrent_warning_threshold,
  input wire [ADC_W-1:0] current_warning2_threshold,
  input wire [ADC_W-1:0] vin_uv_threshold,
  input wire [ADC_W-1:0] vin_ov_threshold,
  input wire [ADC_W-1:0] vaux_uv_threshold,
  input wire [ADC_W-1:0] vaux_ov_threshold,
  input wire [15:0] power_threshold,
  input wire [6:0] own_address,
  input wire ara_ack_phase,
  input wire ara_lost,
  output wire [7:0] ara_address_byte,
  output wire ara_pending,
  output reg hot_swap_gate_on,
  output wire first_alert_output,
  output wire first_alert_oe_n,
  output wire second_alert_output,
  output wire second_alert_oe_n,
  output reg signed [26:0] sense_voltage_nv,
  output reg [20:0] input_voltage_uv
);

  // ---------------------------------------------------------------
  // Synchronisers for analog pin inputs
  // ---------------------------------------------------------------
  wire [5:0] pin_raw;
  reg [5:0] pin_meta;
  reg [5:0] pin_sync;
  assign pin_raw = {fet_health_bad, current_regulation_active_flag, overcurrent_timeout,
                    high_threshold_sense_pin, lower_undervolt_pin, upper_undervolt_pin};

  // Both stages reset to the idle level of every pin, so no false event follows reset.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_meta <= 6'h00;
      pin_sync <= 6'h00;
    end else if (clk_en) begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  wire uv_now;
  wire ov_now;
  wire oc_now;
  assign uv_now = pin_sync[0] | pin_sync[1];
  assign ov_now = pin_sync[2];
  assign oc_now = pin_sync[3];

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  reg [15:0] first_alert_enable_set;
  reg [15:0] second_alert_enable_set;
  reg [7:0] alert_ctrl;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      first_alert_enable_set <= `FWAL_ALERT1_RST;
      second_alert_enable_set <= `FWAL_ALERT2_RST;
      alert_ctrl <= `FWAL_CTRL_RST;
    end else if (clk_en && cmd_wr) begin
      case (cmd_code)
        `FWAL_CMD_ALERT1_CFG: first_alert_enable_set <= cmd_wr_data;
        `FWAL_CMD_ALERT2_CFG: second_alert_enable_set <= cmd_wr_data;
        `FWAL_CMD_ALERT_CTRL: alert_ctrl <= cmd_wr_data[7:0];
        // Unmapped codes leave every register as it was.
        default: alert_ctrl <= alert_ctrl;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Hot swap control and shutdown cause
  // ---------------------------------------------------------------
  reg cmd_on_d;
  reg fault_off;
  reg [1:0] shutdown_cause_field;
  wire cmd_rise;
  wire any_fault;
  assign cmd_rise = hot_swap_on_off_command & ~cmd_on_d;
  assign any_fault = uv_now | ov_now | oc_now;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      cmd_on_d <= 1'b0;
      fault_off <= 1'b0;
      shutdown_cause_field <= `FWAL_CAUSE_NONE;
      hot_swap_gate_on <= 1'b0;
    end else if (clk_en) begin
      cmd_on_d <= hot_swap_on_off_command;
      // A fault latches the gate off until the command is cycled off and on.
      if (any_fault) begin
        fault_off <= 1'b1;
      end else if (cmd_rise) begin
        fault_off <= 1'b0;
      end
      // The cause names the first fault that turned a running output off.
      if (hot_swap_gate_on && any_fault) begin
        if (uv_now) begin
          shutdown_cause_field <= `FWAL_CAUSE_UV;
        end else if (ov_now) begin
          shutdown_cause_field <= `FWAL_CAUSE_OV;
        end else begin
          shutdown_cause_field <= `FWAL_CAUSE_OC;
        end
      end else if ((clear_faults || cmd_rise) && !any_fault) begin
        shutdown_cause_field <= `FWAL_CAUSE_NONE;
      end
      // Warnings are deliberately absent from this term.
      hot_swap_gate_on <= hot_swap_on_off_command & ~fault_off & ~any_fault;
    end
  end

  // ---------------------------------------------------------------
  // Warning comparisons, strictly above or below
  // ---------------------------------------------------------------
  wire ioc_hit;
  wire iw2_hit;
  wire vinuv_hit;
  wire vinov_hit;
  wire vauxuv_hit;
  wire vauxov_hit;
  wire pinop_hit;
  assign ioc_hit = current_sample_valid &
                   (current_reading > overcurrent_warning_threshold);
  assign iw2_hit = current_sample_valid & (alert_ctrl[`FWAL_CTRL_W2_UNDER] ?
                   (current_reading < current_warning2_threshold) :
                   (current_reading > current_warning2_threshold));
  assign vinuv_hit = voltage_sample_valid & (input_voltage_reading < vin_uv_threshold);
  assign vinov_hit = voltage_sample_valid & (input_voltage_reading > vin_ov_threshold);
  assign vauxuv_hit = voltage_sample_valid & (aux_voltage_reading < vaux_uv_threshold);
  assign vauxov_hit = voltage_sample_valid & (aux_voltage_reading > vaux_ov_threshold);
  assign pinop_hit = power_sample_valid & (power_reading > power_threshold);

  // ---------------------------------------------------------------
  // Latched status
  // ---------------------------------------------------------------
  // Set terms are events this cycle; live terms are conditions that survive a clear.
  // Sample warnings have no live term, so the next violating sample sets them afresh.
  wire [15:0] status_set;
  wire [15:0] status_live;
  wire status_clr;
  wire fet_hit_w;
  reg [15:0] status;
  reg [15:0] next_status;
  // The health input is a level from the gate driver, synchronised here through both stages above.
  assign fet_hit_w = pin_sync[5];
  assign status_set = {fet_hit_w, 3'h0, pinop_hit, vauxov_hit, vauxuv_hit, vinov_hit,
                       vinuv_hit, iw2_hit, ioc_hit, pin_sync[4], comm_error_flag,
                       oc_now, ov_now, uv_now};
  assign status_live = {fet_hit_w, 10'h000, pin_sync[4], 1'b0, oc_now, ov_now, uv_now};
  assign status_clr = clear_faults | cmd_rise;

  always @* begin
    next_status = status;
    if (status_clr) begin
      next_status = status & status_live;
    end
    next_status = next_status | status_set;
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      status <= 16'h0000;
    end else if (clk_en) begin
      status <= next_status;
    end
  end

  // ---------------------------------------------------------------
  // Alert state and alert response
  // ---------------------------------------------------------------
  reg first_active;
  reg second_active;
  wire [15:0] new_bits;
  wire first_new;
  wire second_new;
  wire alert_release;
  // A bit counts if it was 0 last cycle or a clear drops it; live bits held through a clear never reassert.
  assign new_bits = next_status & ~(status & ~{16{status_clr}} | status & status_live);
  assign first_new = |(new_bits & first_alert_enable_set);
  assign second_new = |(new_bits & second_alert_enable_set);
  assign alert_release = clear_faults | (ara_ack_phase & ~ara_lost);
  assign ara_pending = first_active | second_active;
  assign ara_address_byte = {own_address, 1'b0};

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      first_active <= 1'b0;
      second_active <= 1'b0;
    end else if (clk_en) begin
      // So an output that sees a fresh event in that cycle may outlast the other one.
      // Both release together; a fresh event in the release cycle still wins.
      first_active <= first_new | (first_active & ~alert_release);
      second_active <= second_new | (second_active & ~alert_release);
    end
  end

  // The pad is only ever pulled low or released; the pull-up supplies the high.
  assign first_alert_output = 1'b0;
  assign second_alert_output = 1'b0;
  assign first_alert_oe_n = ~(first_active ^ alert_ctrl[`FWAL_CTRL_INV1]);
  assign second_alert_oe_n = ~(second_active ^ alert_ctrl[`FWAL_CTRL_INV2]);

  // ---------------------------------------------------------------
  // Code conversion and register reads
  // ---------------------------------------------------------------
  wire signed [13:0] sense_steps;
  wire signed [16:0] sense_lsb;
  wire [12:0] vin_twice;
  assign sense_steps = $signed({2'b00, current_reading}) - $signed({2'b00, `FWAL_SENSE_ZERO});
  assign sense_lsb = alert_ctrl[`FWAL_CTRL_RANGE50] ? $signed({1'b0, `FWAL_LSB50_NV}) :
                     $signed({1'b0, `FWAL_LSB25_NV});
  assign vin_twice = {input_voltage_reading, 1'b1};
  // Full products are kept so that the narrowing below is a deliberate cut.
  // Codes far from zero in the 50 mV range need 27 signed bits of nanovolts.
  wire signed [30:0] sense_prod;
  wire [21:0] vin_prod;
  assign sense_prod = sense_steps * sense_lsb;
  assign vin_prod = vin_twice * `FWAL_HALF_LSBV_UV;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      sense_voltage_nv <= 27'sh0000000;
      input_voltage_uv <= 21'h000000;
      cmd_rd_data <= 16'h0000;
    end else if (clk_en) begin
      if (current_sample_valid) begin
        sense_voltage_nv <= sense_prod[26:0];
      end
      if (voltage_sample_valid) begin
        // 368 uV times (code + 0.5) is 184 uV times (2 * code + 1).
        input_voltage_uv <= vin_prod[20:0];
      end
      // The read word is registered and stands until the next read.
      if (cmd_rd) begin
        case (cmd_code)
          `FWAL_CMD_MFR_STATUS: cmd_rd_data <= {8'h00, status[7:3] != 5'h00,
                                                status[2:0], 2'b00, shutdown_cause_field};
          `FWAL_CMD_ALERT1_CFG: cmd_rd_data <= first_alert_enable_set;
          `FWAL_CMD_ALERT2_CFG: cmd_rd_data <= second_alert_enable_set;
          `FWAL_CMD_ALERT_CTRL: cmd_rd_data <= {8'h00, alert_ctrl};
          `FWAL_CMD_STATUS_ALL: cmd_rd_data <= status;
          default: cmd_rd_data <= 16'h0000;
        endcase
      end
    end
  end

endmodule

// *** bench/fwal_host_model.sv ***
// Host processor model that services alerts by query or by clearing.
`timescale 1ns/1ps
module fwal_host_model (
  input wire ref_clk,
  input wire alert_line,
  input wire svc,
  input wire use_ara,
  output reg clear_faults = 1'h0,
  output reg ara_ack_phase = 1'h0
);
  // A query is only made while the shared line is still low, as a real host would.
  always @(posedge ref_clk) begin
    ara_ack_phase <= svc && use_ara && !alert_line;
    clear_faults <= svc && !use_ara;
  end
endmodule

// *** bench/fwal_alert_chk.sv ***
// Concurrent checks on the alert logic ports.
`timescale 1ns/1ps
module fwal_alert_chk (
  input wire ref_clk,
  input wire rst_n,
  input wire high_threshold_sense_pin,
  input wire overcurrent_timeout,
  input wire clear_faults,
  input wire [6:0] own_address,
  input wire ara_ack_phase,
  input wire ara_lost,
  input wire [7:0] ara_address_byte,
  input wire ara_pending,
  input wire hot_swap_gate_on,
  input wire first_alert_output,
  input wire first_alert_oe_n,
  input wire second_alert_output,
  input wire second_alert_oe_n
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  a_low_only: assert property (!first_alert_output && !second_alert_output)
    else $error("alert pin driven high");
  a_reset_idle: assert property ($rose(rst_n) |->
    first_alert_oe_n && second_alert_oe_n) else $error("alert held after reset");
  a_clear_release: assert property (clear_faults |=> !ara_pending)
    else $error("alert kept after clear");
  a_ara_release: assert property (ara_ack_phase && !ara_lost |=> !ara_pending)
    else $error("alert kept after winning query");
  a_lost_hold: assert property (
    ara_pending && ara_ack_phase && ara_lost && !clear_faults |=> ara_pending)
    else $error("alert dropped after losing query");
  a_ara_addr: assert property (ara_address_byte[7:1] == own_address)
    else $error("query byte lacks own address");
  // Five cycles cover the two synchroniser stages and the gate register.
  a_oc_gate_off: assert property (overcurrent_timeout [*5] |-> !hot_swap_gate_on)
    else $error("gate on during overcurrent");
  a_ov_gate_off: assert property (high_threshold_sense_pin [*5] |-> !hot_swap_gate_on)
    else $error("gate on during overvoltage");
  cover property (ara_ack_phase && !ara_lost);
  cover property ($fell(first_alert_oe_n));
  cover property ($fell(second_alert_oe_n));
endmodule
bind fwal_alert_logic fwal_alert_chk u_chk (.*);

// *** bench/fault_warning_alert_logic_tb.sv ***
// Self-checking bench for the fault, warning and alert logic.
`timescale 1ns/1ps
module fault_warning_alert_logic_tb;
  reg ref_clk = 1'h0, rst_n = 1'h0, clk_en = 1'h1, svc = 1'h0, use_ara = 1'h0, ara_lost = 1'h0;
  reg current_regulation_active_flag = 1'h0, fet_health_bad = 1'h0, comm_error_flag = 1'h0;
  reg hot_swap_on_off_command = 1'h0, cmd_wr = 1'h0, cmd_rd = 1'h0, lower_undervolt_pin = 1'h0;
  reg current_sample_valid = 1'h0, voltage_sample_valid = 1'h0, power_sample_valid = 1'h0;
  reg [2:0] fp = 3'h0;
  reg [6:0] own_address = 7'h2a;
  reg [7:0] cmd_code = 8'h00;
  reg [15:0] cmd_wr_data = 16'h0, power_reading = 16'h1001, power_threshold = 16'h1000;
  reg [11:0] current_reading = 12'h0, input_voltage_reading = 12'h201;
  reg [11:0] aux_voltage_reading = 12'h0ff, overcurrent_warning_threshold = 12'h100;
  reg [11:0] current_warning2_threshold = 12'hfff, vin_uv_threshold = 12'h000;
  reg [11:0] vin_ov_threshold = 12'h200, vaux_uv_threshold = 12'h100, vaux_ov_threshold = 12'hfff;
  wire upper_undervolt_pin = fp[0];
  wire high_threshold_sense_pin = fp[1];
  wire overcurrent_timeout = fp[2];
  wire clear_faults, ara_ack_phase, ara_pending, hot_swap_gate_on;
  wire first_alert_output, first_alert_oe_n, second_alert_output, second_alert_oe_n;
  wire [15:0] cmd_rd_data;
  wire [7:0] ara_address_byte;
  wire signed [26:0] sense_voltage_nv;
  wire [20:0] input_voltage_uv;
  // A pull-up holds the shared line high whenever both open-drain drivers let go.
  wire alert_line = (first_alert_oe_n | first_alert_output) &
                    (second_alert_oe_n | second_alert_output);
  integer mismatches = 0, n_checks = 0, i, k;
  fwal_alert_logic uut (.*);
  fwal_host_model host_m (.ref_clk, .alert_line, .svc, .use_ara, .clear_faults, .ara_ack_phase);
  initial forever #10 ref_clk = ~ref_clk;
  task tick;
    @(posedge ref_clk);
    #2;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] want);
    n_checks = n_checks + 1;
    if (seen !== want) begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, want);
    end
  endtask
  // A read takes d as the expected word under mask m; a write ignores m.
  task acc(input logic w, input logic [7:0] c, input logic [15:0] d, input logic [15:0] m);
    tick;
    cmd_code = c;
    cmd_wr_data = d;
    cmd_wr = w;
    cmd_rd = !w;
    tick;
    cmd_wr = 1'h0;
    cmd_rd = 1'h0;
    if (!w) chk(cmd_rd_data & m, d);
  endtask
  task cur(input logic [11:0] v);
    tick;
    current_reading = v;
    current_sample_valid = 1'h1;
    tick;
    current_sample_valid = 1'h0;
    repeat (3) tick;
  endtask
  task host(input logic a);
    tick;
    use_ara = a;
    svc = 1'h1;
    tick;
    svc = 1'h0;
    repeat (3) tick;
  endtask
  task wrap_up;
    $display("checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    #2;
    rst_n = 1'h1;
    tick;
    chk(alert_line, 1'h1);
    acc(1'h0, 8'hd5, 16'h8000, 16'hffff);
    acc(1'h0, 8'hd6, 16'h0000, 16'hffff);
    acc(1'h0, 8'h55, 16'h0000, 16'hffff);
    fet_health_bad = 1'h1;
    k = 0;
    while (alert_line !== 1'h0 && k < 20) begin
      tick;
      k = k + 1;
    end
    chk(alert_line, 1'h0);
    if (alert_line !== 1'h0) wrap_up;
    chk(second_alert_oe_n, 1'h1);
    fet_health_bad = 1'h0;
    repeat (4) tick;
    host(1'h0);
    chk(alert_line, 1'h1);
    acc(1'h0, 8'he0, 16'h0000, 16'hffff);
    $display("power-up test done");
    hot_swap_on_off_command = 1'h1;
    repeat (3) tick;
    for (i = 0; i < 3; i = i + 1) begin
      chk(hot_swap_gate_on, 1'h1);
      fp = 3'h1 << i;
      repeat (6) tick;
      chk(hot_swap_gate_on, 1'h0);
      acc(1'h0, 8'h80, (16'h10 << i) | 16'(i + 1), 16'hff);
      fp = 3'h0;
      repeat (4) tick;
      acc(1'h0, 8'h80, (16'h10 << i) | 16'(i + 1), 16'hff);
      host(1'h0);
      acc(1'h0, 8'h80, 16'h0, 16'hff);
      hot_swap_on_off_command = 1'h0;
      tick;
      hot_swap_on_off_command = 1'h1;
      repeat (3) tick;
    end
    $display("fault test done");
    acc(1'h1, 8'hd5, 16'h0020, 16'h0);
    cur(12'h100);
    chk(alert_line, 1'h1);
    cur(12'h101);
    chk(first_alert_oe_n, 1'h0);
    chk(second_alert_oe_n, 1'h1);
    chk(sense_voltage_nv, -32'sh152df90);
    chk(ara_address_byte[7:1], 7'h2a);
    ara_lost = 1'h1;
    host(1'h1);
    chk(first_alert_oe_n, 1'h0);
    ara_lost = 1'h0;
    host(1'h1);
    chk(alert_line, 1'h1);
    acc(1'h0, 8'he0, 16'h0020, 16'hffff);
    cur(12'h102);
    chk(alert_line, 1'h1);
    host(1'h0);
    acc(1'h0, 8'he0, 16'h0000, 16'hffff);
    cur(12'h103);
    chk(first_alert_oe_n, 1'h0);
    host(1'h0);
    $display("alert test done");
    acc(1'h1, 8'hd5, 16'h0000, 16'h0);
    acc(1'h1, 8'hd6, 16'h0008, 16'h0);
    current_regulation_active_flag = 1'h1;
    comm_error_flag = 1'h1;
    voltage_sample_valid = 1'h1;
    power_sample_valid = 1'h1;
    tick;
    comm_error_flag = 1'h0;
    voltage_sample_valid = 1'h0;
    power_sample_valid = 1'h0;
    cur(12'h101);
    chk(second_alert_oe_n, 1'h0);
    chk(first_alert_oe_n, 1'h1);
    chk(hot_swap_gate_on, 1'h1);
    chk(input_voltage_uv, 21'h2e228);
    acc(1'h0, 8'he0, 16'h0b38, 16'hffff);
    current_regulation_active_flag = 1'h0;
    repeat (3) tick;
    host(1'h0);
    chk(alert_line, 1'h1);
    acc(1'h0, 8'he0, 16'h0000, 16'hffff);
    acc(1'h1, 8'hd8, 16'h0001, 16'h0);
    tick;
    chk(first_alert_oe_n, 1'h0);
    acc(1'h1, 8'hd8, 16'h0000, 16'h0);
    acc(1'h1, 8'hd8, 16'h000c, 16'h0);
    acc(1'h0, 8'hd8, 16'h000c, 16'hffff);
    acc(1'h1, 8'hd5, 16'h0040, 16'h0);
    cur(12'h101);
    chk(first_alert_oe_n, 1'h0);
    chk(sense_voltage_nv, -32'sh2a4ed3e);
    acc(1'h0, 8'he0, 16'h0060, 16'hffff);
    host(1'h0);
    chk(alert_line, 1'h1);
    $display("warning test done");
    wrap_up;
  end
endmodule
